// ---- dv/asramc_ctrl_monitor.sv ----
/* checker for the controller pin sequence and request timing.
   assumes bind onto asramc_ctrl, one clock, sync reset. */
`timescale 1ns/1ps
`default_nettype none
module asramc_ctrl_monitor #(
    parameter int ADDR_W = 15,
    parameter int DATA_W = 8
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_write,
    input wire logic rsp_valid,
    input wire logic [ADDR_W-1:0] address_pins,
    input wire logic select_n,
    input wire logic write_n,
    input wire logic drive_n,
    input wire logic [DATA_W-1:0] data_pins_out,
    input wire logic data_pins_oe
);
    // ------------------------------------------------------------
    // pin sequence checks
    // ------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    AST_READ_NO_STROBE: assert property (
        !select_n && !drive_n |-> write_n) else $error("strobe in read");
    // select and drive stand low for three cycles in a read
    AST_READ_SPAN: assert property (
        $fell(drive_n) |=> !drive_n [*2] ##1 (drive_n && select_n))
        else $error("read access span wrong");
    AST_RSP_AT_END: assert property (
        $rose(drive_n) |-> rsp_valid) else $error("no response at end");
    AST_ADDR_HELD: assert property (
        !select_n && !$fell(select_n) |-> $stable(address_pins))
        else $error("address moved while selected");
    // strobe stands low for two cycles
    AST_WR_PULSE: assert property (
        $fell(write_n) |=> !write_n ##1 $rose(write_n))
        else $error("bad strobe width");
    AST_SEL_BEFORE_END: assert property (
        $rose(write_n) |-> !select_n && !$past(select_n, 2))
        else $error("select too short");
    AST_ADDR_BEFORE_END: assert property (
        $rose(write_n) |-> $past(address_pins, 2) == address_pins)
        else $error("address late for write");
    AST_DATA_SETUP: assert property (
        !write_n |-> data_pins_oe && $stable(data_pins_out))
        else $error("write data not set up");
    // setup, two strobe cycles and a hold cycle before ready again
    AST_WRITE_SPAN: assert property (
        req_valid && req_ready && req_write |=> !req_ready [*5] ##1
        req_ready) else $error("write cycle length wrong");
    // covers for the main traffic
    cover property (req_valid && req_ready && req_write);
    cover property (req_valid && req_ready && !req_write);
    cover property ($rose(rsp_valid));
endmodule : asramc_ctrl_monitor
bind asramc_ctrl asramc_ctrl_monitor #(.ADDR_W(ADDR_W),
    .DATA_W(DATA_W)) u_mon (.ref_clk(ref_clk), .reset_n(reset_n),
    .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .rsp_valid(rsp_valid),
    .address_pins(address_pins), .select_n(select_n),
    .write_n(write_n), .drive_n(drive_n),
    .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe));
`default_nettype wire

// ---- dv/asramc_sram_model.sv ----
/* behavioural 32K x 8 static memory, slowest grade delays.
   assumes the bench resolves the data wire from both drivers. */
`timescale 1ns/1ps
`default_nettype none
module asramc_sram_model (
    input wire logic [14:0] address_pins,
    input wire logic select_n,
    input wire logic write_n,
    input wire logic drive_n,
    input wire logic [7:0] dq_in,
    input wire logic dq_oe,
    output logic [7:0] dq_q
);
    logic [7:0] mem [0:32767];
    logic [7:0] dout;
    logic [7:0] last;
    logic en = 1'b0;
    wire rd = !select_n && !drive_n && write_n;
    wire wr = !select_n && !write_n;
    always @(negedge wr) mem[address_pins] = dq_in;
    always @(rd) en <= #((rd === 1'b1) ? 7 : 6) (rd === 1'b1);
    // old data held, junk, then new word
    always @(address_pins) begin
        dout <= #4 ~mem[address_pins];
        dout <= #12 mem[address_pins];
    end
    // word shown as the pins turn on, fresh after a
    // write to the same address; no junk here, access stays in time
    always @(posedge en) dout <= mem[address_pins];
    // floating pins show the inverse of the last level
    always @* if (dq_oe) last = dq_in; else if (en) last = dout;
    assign dq_q = en ? dout : ~last;
endmodule : asramc_sram_model
`default_nettype wire

// ---- dv/tb_async_sram_32k_x8_interface.sv ----
/* self-checking bench for asramc_ctrl against the memory model.
   assumes the design files and the monitor bind are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_async_sram_32k_x8_interface;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [14:0] req_addr = 15'h0000;
    logic [7:0] req_wdata = 8'h00;
    logic req_ready, rsp_valid, select_n, write_n, drive_n, data_pins_oe;
    logic [7:0] rsp_rdata, data_pins_out, dq_q;
    logic [14:0] address_pins;
    int num_errors = 0;
    int num_checks = 0;
    wire logic [7:0] bus = data_pins_oe ? data_pins_out : dq_q;
    // ------------------------------------------------------------
    // clock, design and memory
    // ------------------------------------------------------------
    always #10 ref_clk = ~ref_clk;
    asramc_ctrl uut (.ref_clk(ref_clk), .reset_n(reset_n),
        .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .address_pins(address_pins),
        .select_n(select_n), .write_n(write_n), .drive_n(drive_n),
        .data_pins_in(bus), .data_pins_out(data_pins_out),
        .data_pins_oe(data_pins_oe));
    asramc_sram_model u_mem (.address_pins(address_pins),
        .select_n(select_n), .write_n(write_n), .drive_n(drive_n),
        .dq_in(data_pins_out), .dq_oe(data_pins_oe), .dq_q(dq_q));
    task automatic chk(input string what, input logic [31:0] e,
        input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s exp %0h got %0h", what, e, g);
        end
    endtask : chk
    // hold the request until taken, then drop it
    task automatic send(input logic w, input logic [14:0] a,
        input logic [7:0] d);
        int n;
        n = 0;
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        while (req_ready !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        @(negedge ref_clk);
        req_valid = 1'b0;
    endtask : send
    task automatic await(input logic rd, output int n);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while ((rd ? rsp_valid : req_ready) !== 1'b1 && n < 30);
    endtask : await
    // ready returns five cycles after the take
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        int n;
        send(1'b1, a, d);
        await(1'b0, n);
        chk("write span", 5, n);
    endtask : wr
    // answer pulses four cycles after the take
    task automatic rd(input logic [14:0] a, input logic [7:0] e);
        int n;
        send(1'b0, a, 8'h00);
        await(1'b1, n);
        chk("read latency", 4, n);
        chk("read data", e, rsp_rdata);
    endtask : rd
    task automatic test_idle;
        chk("controls", 3'h7, {select_n, write_n, drive_n});
        chk("data drive", 0, data_pins_oe);
        $display("test idle done");
    endtask : test_idle
    // array ends and a middle word, back to back
    task automatic test_bounds;
        logic [14:0] aa [3] = '{15'h0000, 15'h7FFF, 15'h2AAA};
        logic [7:0] dd [3] = '{8'h00, 8'hFF, 8'hA5};
        for (int i = 0; i < 3; i++) wr(aa[i], dd[i]);
        for (int i = 0; i < 3; i++) rd(aa[i], dd[i]);
        $display("test bounds done");
    endtask : test_bounds
    task automatic test_overwrite;
        wr(15'h1234, 8'h11);
        wr(15'h1234, 8'hEE);
        rd(15'h1234, 8'hEE);
        rd(15'h7FFF, 8'hFF);
        $display("test overwrite done");
    endtask : test_overwrite
    // a write offered while busy and withdrawn must leave no trace;
    // it is dropped before the answer so the pulse is still seen
    task automatic test_refused;
        int n;
        send(1'b0, 15'h2AAA, 8'h00);
        @(negedge ref_clk);
        req_valid = 1'b1;
        req_write = 1'b1;
        req_wdata = 8'h5A;
        repeat (2) @(negedge ref_clk);
        req_valid = 1'b0;
        await(1'b1, n);
        chk("busy wait", 1, n);
        chk("busy read", 8'hA5, rsp_rdata);
        @(negedge ref_clk);
        chk("data stands", 8'hA5, rsp_rdata);
        rd(15'h2AAA, 8'hA5);
        test_idle();
        $display("test refused done");
    endtask : test_refused
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (5) @(negedge ref_clk);
        reset_n = 1'b1;
        test_idle();
        test_bounds();
        test_overwrite();
        test_refused();
        final_report();
    end
    // tests need about 80 cycles; cut off at 2000
    initial begin
        #40000;
        num_errors++;
        final_report();
    end
endmodule : tb_async_sram_32k_x8_interface
`default_nettype wire

// ---- pkg/asramc_cnt_if.sv ----
/*
 * Carrier between the sequencer and its phase timer.
 * Assumes both ends share ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none

interface asramc_cnt_if;
    logic load;
    logic [3:0] count;
    logic done;
    modport seq (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface : asramc_cnt_if

`default_nettype wire

// ---- pkg/asramc_map.svh ----
/*
 * Timing constants of the external asynchronous memory controller:
 * printed times in ns and derived cycle counts at the 50 MHz ref_clk.
 * Assumes it is included by bare name; holds definitions only.
 */
`ifndef ASRAMC_MAP_SVH
`define ASRAMC_MAP_SVH

// -----------------------------------------------------------------------
// clock
// -----------------------------------------------------------------------
`define ASRAMC_CLK_PERIOD_NS 20

// -----------------------------------------------------------------------
// slowest grade figures (ns); controller meets every grade with these
// -----------------------------------------------------------------------
`define ASRAMC_CYCLE_TIME_NS 12
`define ASRAMC_ADDRESS_ACCESS_TIME_NS 12
`define ASRAMC_SELECT_ACCESS_TIME_NS 12
`define ASRAMC_DRIVE_ACCESS_TIME_NS 7
`define ASRAMC_ADDR_TO_WRITE_END_NS 10
`define ASRAMC_WRITE_PULSE_NS 9
`define ASRAMC_SELECT_TO_WRITE_END_NS 9
`define ASRAMC_DATA_SETUP_TIME_NS 6
`define ASRAMC_RELEASE_NS 6

// -----------------------------------------------------------------------
// derived counts: least times round up, never below one cycle
// -----------------------------------------------------------------------
`define ASRAMC_CEIL_CYC(ns) \
    ((((ns) + `ASRAMC_CLK_PERIOD_NS - 1) / `ASRAMC_CLK_PERIOD_NS) < 1 ? 1 : \
     (((ns) + `ASRAMC_CLK_PERIOD_NS - 1) / `ASRAMC_CLK_PERIOD_NS))
`define ASRAMC_READ_CYC (`ASRAMC_CEIL_CYC(`ASRAMC_ADDRESS_ACCESS_TIME_NS))
`define ASRAMC_WRITE_CYC (`ASRAMC_CEIL_CYC(`ASRAMC_ADDR_TO_WRITE_END_NS))
`define ASRAMC_TURN_CYC (`ASRAMC_CEIL_CYC(`ASRAMC_RELEASE_NS))

// -----------------------------------------------------------------------
// array shape
// -----------------------------------------------------------------------
`define ASRAMC_ADDR_W 15
`define ASRAMC_DATA_W 8

`endif

// ---- pkg/asramc_pkg.sv ----
/*
 * Types of the asynchronous memory controller.
 * Assumes asramc_map.svh is on the include path.
 */
`include "asramc_map.svh"

package asramc_pkg;
    typedef enum logic [2:0] {
        ASRAMC_IDLE,
        ASRAMC_RD_ACCESS,
        ASRAMC_RD_TURN,
        ASRAMC_WR_SETUP,
        ASRAMC_WR_PULSE,
        ASRAMC_WR_HOLD
    } asramc_state_t;
endpackage : asramc_pkg

// ---- src/asramc_ctrl.sv ----
/*
 * Controller for a 32K x 8 asynchronous static memory: turns one-word
 * read and write requests into chip select, write strobe, output drive
 * and data pin activity with the slowest grade timing.
 * Assumes the memory sits on the pins directly; the testbench resolves
 * the data_pins wire from data_pins_oe.
 */
// Functional notes
// - read keeps strobe high, select and drive low
// - read cycle long enough for address access
// - address valid before select falls
// - write cycle meets least cycle time
// - address held long enough before write end
// - strobe pulse meets least width
// - write data stable before write end
// - select held long enough in write
`timescale 1ns/1ps
`default_nettype none

`include "asramc_map.svh"

module asramc_ctrl
    import asramc_pkg::*;
#(
    parameter int ADDR_W = `ASRAMC_ADDR_W,
    parameter int DATA_W = `ASRAMC_DATA_W
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic [ADDR_W-1:0] address_pins,
    output logic select_n,
    output logic write_n,
    output logic drive_n,
    input wire logic [DATA_W-1:0] data_pins_in,
    output logic [DATA_W-1:0] data_pins_out,
    output logic data_pins_oe
);
    asramc_state_t state_r;
    asramc_cnt_if cnt ();
    logic [DATA_W-1:0] din_meta_r;
    logic [DATA_W-1:0] din_sync_r;

    function automatic logic [3:0] cyc4(input int n);
        cyc4 = 4'(n);
    endfunction : cyc4

    asramc_timer u_timer (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .cnt(cnt)
    );

    // -------------------------------------------------------------------
    // pin input synchroniser
    // -------------------------------------------------------------------
    // two stages since the memory answers with no relation to ref_clk;
    // the extra latency is covered by the read access phase length
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            din_meta_r <= '0;
            din_sync_r <= '0;
        end else begin
            din_meta_r <= data_pins_in;
            din_sync_r <= din_meta_r;
        end
    end

    // -------------------------------------------------------------------
    // sequencer
    // -------------------------------------------------------------------
    assign req_ready = (state_r == ASRAMC_IDLE);

    // timer loads on entry to each timed phase
    always_comb begin
        cnt.load = 1'b0;
        cnt.count = 4'h0;
        case (state_r)
            ASRAMC_IDLE: begin
                if (req_valid) begin
                    cnt.load = 1'b1;
                    cnt.count = req_write ? cyc4(1) : cyc4(`ASRAMC_READ_CYC + 2);
                end
            end
            ASRAMC_WR_SETUP: begin
                if (cnt.done) begin
                    cnt.load = 1'b1;
                    cnt.count = cyc4(`ASRAMC_WRITE_CYC);
                end
            end
            ASRAMC_RD_ACCESS: begin
                if (cnt.done) begin
                    cnt.load = 1'b1;
                    cnt.count = cyc4(`ASRAMC_TURN_CYC);
                end
            end
            default: begin
                cnt.load = 1'b0;
            end
        endcase
    end

    // state advance
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_r <= ASRAMC_IDLE;
        end else begin
            case (state_r)
                ASRAMC_IDLE: begin
                    if (req_valid) begin
                        state_r <= req_write ? ASRAMC_WR_SETUP : ASRAMC_RD_ACCESS;
                    end
                end
                ASRAMC_RD_ACCESS: begin
                    if (cnt.done) begin
                        state_r <= ASRAMC_RD_TURN;
                    end
                end
                ASRAMC_RD_TURN: begin
                    if (cnt.done) begin
                        state_r <= ASRAMC_IDLE;
                    end
                end
                ASRAMC_WR_SETUP: begin
                    if (cnt.done) begin
                        state_r <= ASRAMC_WR_PULSE;
                    end
                end
                ASRAMC_WR_PULSE: begin
                    if (cnt.done) begin
                        state_r <= ASRAMC_WR_HOLD;
                    end
                end
                ASRAMC_WR_HOLD: begin
                    state_r <= ASRAMC_IDLE;
                end
                default: begin
                    state_r <= ASRAMC_IDLE;
                end
            endcase
        end
    end

    // -------------------------------------------------------------------
    // address and write data pins
    // -------------------------------------------------------------------
    // address set on the take, a cycle before select falls
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            address_pins <= '0;
            data_pins_out <= '0;
        end else if (req_ready && req_valid) begin
            address_pins <= req_addr;
            data_pins_out <= req_wdata;
        end
    end

    // -------------------------------------------------------------------
    // control pins, all registered so they never glitch
    // -------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            select_n <= 1'b1;
            write_n <= 1'b1;
            drive_n <= 1'b1;
            data_pins_oe <= 1'b0;
        end else begin
            case (state_r)
                ASRAMC_IDLE: begin
                    select_n <= 1'b1;
                    write_n <= 1'b1;
                    drive_n <= 1'b1;
                    data_pins_oe <= 1'b0;
                end
                ASRAMC_RD_ACCESS: begin
                    select_n <= cnt.done;
                    write_n <= 1'b1;
                    drive_n <= cnt.done;
                    data_pins_oe <= 1'b0;
                end
                ASRAMC_WR_SETUP: begin
                    select_n <= 1'b0;
                    write_n <= !cnt.done;
                    drive_n <= 1'b1;
                    data_pins_oe <= 1'b1;
                end
                ASRAMC_WR_PULSE: begin
                    select_n <= 1'b0;
                    write_n <= cnt.done;
                    drive_n <= 1'b1;
                    data_pins_oe <= 1'b1;
                end
                default: begin
                    // hold data one cycle past select end
                    select_n <= 1'b1;
                    write_n <= 1'b1;
                    drive_n <= 1'b1;
                    data_pins_oe <= (state_r == ASRAMC_WR_HOLD);
                end
            endcase
        end
    end

    // -------------------------------------------------------------------
    // read answer
    // -------------------------------------------------------------------
    // sample after access times
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= (state_r == ASRAMC_RD_ACCESS) && cnt.done;
            if ((state_r == ASRAMC_RD_ACCESS) && cnt.done) begin
                rsp_rdata <= din_sync_r;
            end
        end
    end
endmodule : asramc_ctrl

`default_nettype wire

// ---- src/asramc_timer.sv ----
/*
 * Phase timer: counts down a loaded number of ref_clk cycles.
 * Assumes load comes from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module asramc_timer (
    input wire logic ref_clk,
    input wire logic reset_n,
    asramc_cnt_if.tmr cnt
);
    logic [3:0] remain_r;

    // -------------------------------------------------------------------
    // down counter; done once it reaches zero
    // -------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            remain_r <= 4'h0;
        end else if (cnt.load) begin
            remain_r <= cnt.count;
        end else if (remain_r != 4'h0) begin
            remain_r <= remain_r - 4'h1;
        end
    end

    // done must not look at load: the sequencer loads on done, and a
    // path back through load would close a combinational loop
    assign cnt.done = (remain_r == 4'h0);
endmodule : asramc_timer

`default_nettype wire
